// ### core/tiss_regs.svh
// Purpose: register map, field positions and encodings of the
//          timer input source selector
// Assumes: 8-bit registers, one per aligned byte address
// Notes:   definitions only
`ifndef TISS_REGS_SVH
`define TISS_REGS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TISS_ADDR_IT    32'hff77_0418
`define TISS_ADDR_CHAIN 32'hff77_1000
`define TISS_ADDR_RX    32'hff77_1004
`define TISS_ADDR_TS    32'hff77_2014

// ****************************************************************
// implemented bits and reset value
// ****************************************************************
`define TISS_MASK_IT    8'h03
`define TISS_MASK_CHAIN 8'hff
`define TISS_MASK_RX    8'h4f
`define TISS_MASK_TS    8'h3f
`define TISS_SEL_RST    8'h00
`define TISS_RD_IDLE    8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define TISS_RX_TIN2_BIT  6
`define TISS_RX_TIN1_MSB  3
`define TISS_RX_TIN1_LSB  2
`define TISS_RX_TIN0_MSB  1
`define TISS_RX_TIN0_LSB  0
`define TISS_IT_TIN0_BIT  0
`define TISS_IT_TIN15_BIT 1
`define TISS_TS_TIN15_BIT 5
`define TISS_TS_FIRST_TIN 10
`define TISS_TS_BITS      6

// ****************************************************************
// two-bit source encodings
// ****************************************************************
`define TISS_ENC_CAN    2'b01
`define TISS_ENC_SERIAL 2'b11

`endif

// ### core/tiss_pkg.sv
// Purpose: types shared by the timer input source selector
// Assumes: nothing beyond the register header
// Notes:   bus request and source groups travel as packed structs
package tiss_pkg;

	// ****************************************************************
	// register decode result
	// ****************************************************************
	typedef enum {
		reg_none,
		reg_it,
		reg_chain,
		reg_rx,
		reg_ts
	} tiss_reg_t;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} tiss_bus_req_t;

	typedef struct packed {
		logic [15:0] port_pin;
		logic        serial2_receive_line;
		logic        serial10_receive_line;
		logic        serial11_receive_line;
	} tiss_pin_t;

	typedef struct packed {
		logic [5:0] can_timestamp_out;
		logic       interval_timer_ch3_irq;
	} tiss_onchip_t;

endpackage

// ### core/tiss_top.sv
// Purpose: source selector in front of the 16 timer channel inputs
// Assumes: pins arrive asynchronously, on-chip sources share mclk
// Notes:   one cycle of output register after the selector
//
// Summary of operation
// - rx bit6: input 2 pin or serial2
// - rx bits3:2: input 1 source, can1/serial11
// - rx bits1:0: input 0 source, can0/second level
// - irq-select bit0: serial10 or interval irq
// - irq-select bit1: input 15 pin or irq
// - ts bit5: input 15 pin or can5
// - ts bit4: input 14 pin or can4
// - ts bit3: input 13 pin or can3
// - ts bit2: input 12 pin or can2
// - ts bit1: input 11 pin or can1
// - ts bit0: input 10 pin or can0
// - all four registers read/write, unimplemented bits read as 0
// - odd input may take even neighbour
`timescale 1ns/1ps
`include "tiss_regs.svh"

module tiss_top #(
	parameter int NUM_INPUTS = 16
) (
	// clock, reset, enable
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire logic                   ce,
	// register port
	input  wire tiss_pkg::tiss_bus_req_t bus_req,
	output logic [7:0]                  rd_data,
	// selectable sources
	input  wire tiss_pkg::tiss_pin_t    pins,
	input  wire tiss_pkg::tiss_onchip_t onchip,
	// timer side
	output logic [NUM_INPUTS-1:0]       timer_channel_input
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// each channel has its own fixed source list, so width is fixed
	if (NUM_INPUTS != 16) begin : g_bad_width
		$error("tiss_top serves exactly 16 timer inputs");
	end

	// ****************************************************************
	// address decode
	// ****************************************************************
	function automatic tiss_pkg::tiss_reg_t reg_decode(
		input logic [31:0] addr
	);
		tiss_pkg::tiss_reg_t r;
		r = tiss_pkg::reg_none;
		if (addr == `TISS_ADDR_IT) begin
			r = tiss_pkg::reg_it;
		end else if (addr == `TISS_ADDR_CHAIN) begin
			r = tiss_pkg::reg_chain;
		end else if (addr == `TISS_ADDR_RX) begin
			r = tiss_pkg::reg_rx;
		end else if (addr == `TISS_ADDR_TS) begin
			r = tiss_pkg::reg_ts;
		end
		return r;
	endfunction

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	tiss_pkg::tiss_pin_t pin_s1_ff;
	tiss_pkg::tiss_pin_t pin_s2_ff;
	tiss_pkg::tiss_pin_t nxt_pin_s1;
	tiss_pkg::tiss_pin_t nxt_pin_s2;

	always_comb begin
		nxt_pin_s1 = pins;
		nxt_pin_s2 = pin_s1_ff;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else if (ce) begin
			pin_s1_ff <= nxt_pin_s1;
			pin_s2_ff <= nxt_pin_s2;
		end
	end

	// ****************************************************************
	// select registers
	// ****************************************************************
	logic [7:0]          it_sel_ff;
	logic [7:0]          chain_sel_ff;
	logic [7:0]          rx_sel_ff;
	logic [7:0]          ts_sel_ff;
	logic [7:0]          nxt_it_sel;
	logic [7:0]          nxt_chain_sel;
	logic [7:0]          nxt_rx_sel;
	logic [7:0]          nxt_ts_sel;
	tiss_pkg::tiss_reg_t wr_reg;

	// the port is byte wide, so every access is a whole register
	always_comb begin
		wr_reg        = reg_decode(bus_req.addr);
		nxt_it_sel    = it_sel_ff;
		nxt_chain_sel = chain_sel_ff;
		nxt_rx_sel    = rx_sel_ff;
		nxt_ts_sel    = ts_sel_ff;
		if (bus_req.wr) begin
			if (wr_reg == tiss_pkg::reg_it) begin
				nxt_it_sel = bus_req.wdata & `TISS_MASK_IT;
			end else if (wr_reg == tiss_pkg::reg_chain) begin
				nxt_chain_sel = bus_req.wdata & `TISS_MASK_CHAIN;
			end else if (wr_reg == tiss_pkg::reg_rx) begin
				nxt_rx_sel = bus_req.wdata & `TISS_MASK_RX;
			end else if (wr_reg == tiss_pkg::reg_ts) begin
				nxt_ts_sel = bus_req.wdata & `TISS_MASK_TS;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			it_sel_ff    <= `TISS_SEL_RST;
			chain_sel_ff <= `TISS_SEL_RST;
			rx_sel_ff    <= `TISS_SEL_RST;
			ts_sel_ff    <= `TISS_SEL_RST;
		end else if (ce) begin
			it_sel_ff    <= nxt_it_sel;
			chain_sel_ff <= nxt_chain_sel;
			rx_sel_ff    <= nxt_rx_sel;
			ts_sel_ff    <= nxt_ts_sel;
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	logic [7:0]          rd_data_ff;
	logic [7:0]          nxt_rd_data;
	tiss_pkg::tiss_reg_t rd_reg;

	// data stands only in the cycle after the strobe; unmapped reads 0
	always_comb begin
		rd_reg      = reg_decode(bus_req.addr);
		nxt_rd_data = `TISS_RD_IDLE;
		if (bus_req.rd) begin
			if (rd_reg == tiss_pkg::reg_it) begin
				nxt_rd_data = it_sel_ff;
			end else if (rd_reg == tiss_pkg::reg_chain) begin
				nxt_rd_data = chain_sel_ff;
			end else if (rd_reg == tiss_pkg::reg_rx) begin
				nxt_rd_data = rx_sel_ff;
			end else if (rd_reg == tiss_pkg::reg_ts) begin
				nxt_rd_data = ts_sel_ff;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_data_ff <= `TISS_RD_IDLE;
		end else if (ce) begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign rd_data = rd_data_ff;

	// ****************************************************************
	// source selectors
	// ****************************************************************
	logic [NUM_INPUTS-1:0] pre_sel;
	logic                  lvl2_sel;
	logic [5:0]            can_ts;
	logic                  jirq;

	// purely combinational, so a write steers the next output edge
	always_comb begin
		can_ts   = onchip.can_timestamp_out;
		jirq     = onchip.interval_timer_ch3_irq;
		pre_sel  = pin_s2_ff.port_pin;
		lvl2_sel = it_sel_ff[`TISS_IT_TIN0_BIT] ? jirq
			: pin_s2_ff.serial10_receive_line;
		case (rx_sel_ff[`TISS_RX_TIN0_MSB:`TISS_RX_TIN0_LSB])
			`TISS_ENC_CAN: pre_sel[0] = can_ts[0];
			`TISS_ENC_SERIAL: pre_sel[0] = lvl2_sel;
			default: pre_sel[0] = pin_s2_ff.port_pin[0];
		endcase
		case (rx_sel_ff[`TISS_RX_TIN1_MSB:`TISS_RX_TIN1_LSB])
			`TISS_ENC_CAN: pre_sel[1] = can_ts[1];
			`TISS_ENC_SERIAL: begin
				pre_sel[1] = pin_s2_ff.serial11_receive_line;
			end
			default: pre_sel[1] = pin_s2_ff.port_pin[1];
		endcase
		if (rx_sel_ff[`TISS_RX_TIN2_BIT]) begin
			pre_sel[2] = pin_s2_ff.serial2_receive_line;
		end
		if (it_sel_ff[`TISS_IT_TIN15_BIT]) begin
			pre_sel[15] = jirq;
		end
		// time stamp bit k replaces the pin of input 10+k
		for (int k = 0; k < `TISS_TS_BITS; k++) begin
			if (ts_sel_ff[k]) begin
				pre_sel[`TISS_TS_FIRST_TIN + k] = can_ts[k];
			end
		end
		// handled by the loop above
		// on input 15 the time stamp wins over the interval irq
	end

	// ****************************************************************
	// odd-input chaining and output register
	// ****************************************************************
	logic [NUM_INPUTS-1:0] tin_ff;
	logic [NUM_INPUTS-1:0] nxt_tin;

	always_comb begin
		nxt_tin = pre_sel;
		for (int g = 0; g < NUM_INPUTS / 2; g++) begin
			if (chain_sel_ff[g]) begin
				nxt_tin[2*g+1] = pre_sel[2*g];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tin_ff <= '0;
		end else if (ce) begin
			tin_ff <= nxt_tin;
		end
	end

	assign timer_channel_input = tin_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_tin2_rx: assert property (
		@(posedge mclk) disable iff (srst)
		ce |=> tin_ff[2] ==
			($past(rx_sel_ff[`TISS_RX_TIN2_BIT])
				? $past(pin_s2_ff.serial2_receive_line)
				: $past(pin_s2_ff.port_pin[2])))
		else $error("input 2 source wrong");

	a_tin1_src: assert property (
		@(posedge mclk) disable iff (srst)
		rx_sel_ff[3:2] == 2'b11 |->
			pre_sel[1] == pin_s2_ff.serial11_receive_line)
		else $error("input 1 serial source wrong");

	a_tin0_can: assert property (
		@(posedge mclk) disable iff (srst)
		rx_sel_ff[1:0] == 2'b01 |-> pre_sel[0] == can_ts[0])
		else $error("input 0 time stamp source wrong");

	a_lvl2_serial: assert property (
		@(posedge mclk) disable iff (srst)
		rx_sel_ff[1:0] == 2'b11 && !it_sel_ff[0] |->
			pre_sel[0] == pin_s2_ff.serial10_receive_line)
		else $error("second level selector wrong");

	a_tin15_irq: assert property (
		@(posedge mclk) disable iff (srst)
		it_sel_ff[1] && !ts_sel_ff[5] |-> pre_sel[15] == jirq)
		else $error("input 15 irq source wrong");

	a_tin15_can: assert property (
		@(posedge mclk) disable iff (srst)
		ts_sel_ff[5] |-> pre_sel[15] == can_ts[5])
		else $error("input 15 time stamp source wrong");

	a_tin12_pin: assert property (
		@(posedge mclk) disable iff (srst)
		!ts_sel_ff[2] |-> pre_sel[12] == pin_s2_ff.port_pin[12])
		else $error("input 12 pin source wrong");

	a_pin_code10: assert property (
		@(posedge mclk) disable iff (srst)
		rx_sel_ff[3:2] == 2'b10 |-> pre_sel[1] == pin_s2_ff.port_pin[1])
		else $error("input 1 code 10 not pin");

	a_reg_readback: assert property (
		@(posedge mclk) disable iff (srst)
		ce && bus_req.wr && bus_req.addr == `TISS_ADDR_RX ##1
			ce && bus_req.rd && bus_req.addr == `TISS_ADDR_RX |=>
			rd_data == ($past(bus_req.wdata, 2) & `TISS_MASK_RX))
		else $error("receive select read back wrong");

	a_reset_zero: assert property (
		@(posedge mclk)
		$past(srst) |-> rx_sel_ff == `TISS_SEL_RST
			&& ts_sel_ff == `TISS_SEL_RST
			&& it_sel_ff == `TISS_SEL_RST
			&& chain_sel_ff == `TISS_SEL_RST)
		else $error("select register not zero after reset");

	a_write_effect: assert property (
		@(posedge mclk) disable iff (srst)
		ce && bus_req.wr && bus_req.addr == `TISS_ADDR_TS
			&& bus_req.wdata[4] |=> pre_sel[14] == can_ts[4])
		else $error("time stamp select not effective");

	a_tin15_pin: assert property (
		@(posedge mclk) disable iff (srst)
		!it_sel_ff[`TISS_IT_TIN15_BIT] && !ts_sel_ff[`TISS_TS_TIN15_BIT]
			|-> pre_sel[15] == pin_s2_ff.port_pin[15])
		else $error("input 15 pin source wrong");

	a_tin0_pin: assert property (
		@(posedge mclk) disable iff (srst)
		rx_sel_ff[`TISS_RX_TIN0_MSB:`TISS_RX_TIN0_LSB] == 2'b00
			|-> pre_sel[0] == pin_s2_ff.port_pin[0])
		else $error("input 0 code 00 not pin");

	a_rd_idle: assert property (
		@(posedge mclk) disable iff (srst)
		ce && !bus_req.rd |=> rd_data == `TISS_RD_IDLE)
		else $error("read data outside read cycle");

	// a low enable must freeze selection and outputs alike
	a_ce_freeze: assert property (
		@(posedge mclk) disable iff (srst)
		!ce |=> $stable(tin_ff) && $stable(rx_sel_ff) && $stable(ts_sel_ff)
			&& $stable(it_sel_ff) && $stable(chain_sel_ff))
		else $error("state moved while clock enable low");

	// inputs 10 to 14 follow their time stamp bit; 15 is checked above
	for (genvar k = 0; k < `TISS_TS_BITS - 1; k++) begin : g_ts_chk
		a_ts_can: assert property (
			@(posedge mclk) disable iff (srst)
			ts_sel_ff[k] |-> pre_sel[`TISS_TS_FIRST_TIN + k] == can_ts[k])
			else $error("time stamp source wrong");
		a_ts_pin: assert property (
			@(posedge mclk) disable iff (srst)
			!ts_sel_ff[k] |-> pre_sel[`TISS_TS_FIRST_TIN + k]
				== pin_s2_ff.port_pin[`TISS_TS_FIRST_TIN + k])
			else $error("time stamp pin source wrong");
	end

	for (genvar g = 0; g < NUM_INPUTS / 2; g++) begin : g_chain_chk
		a_chain_odd: assert property (
			@(posedge mclk) disable iff (srst)
			ce && chain_sel_ff[g] |=> tin_ff[2*g+1] == $past(pre_sel[2*g]))
			else $error("odd input chaining wrong");
	end

endmodule

// ### bench/tiss_edge_model.sv
// Purpose: edge detectors of the timer channels behind the selector
// Assumes: selected inputs are levels on mclk
// Notes:   sticky rising-edge flags, cleared by srst
`timescale 1ns/1ps

module tiss_edge_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// selected timer inputs
	input  wire logic [15:0] tin,
	// detected edges
	output logic      [15:0] rise_seen
);
	logic [15:0] prev_ff;

	// flags stay set so a short pulse between checks is not lost
	always_ff @(posedge mclk) begin
		if (srst) begin
			prev_ff   <= 16'h0000;
			rise_seen <= 16'h0000;
		end else begin
			prev_ff   <= tin;
			rise_seen <= rise_seen | (tin & ~prev_ff);
		end
	end
endmodule

// ### bench/tb_tiss_top.sv
// Purpose: self-checking bench of the timer input source selector
// Assumes: one clock, sources driven as one 26-bit pattern
// Notes:   expected outputs come from a local reference of the muxes
`timescale 1ns/1ps
`include "tiss_regs.svh"

module tb_tiss_top;
	logic                   mclk;
	logic                   srst;
	logic                   ce;
	tiss_pkg::tiss_bus_req_t bus_req;
	logic [7:0]             rd_data;
	tiss_pkg::tiss_pin_t    pins;
	tiss_pkg::tiss_onchip_t onchip;
	logic [15:0]            tin;
	logic [15:0]            rise_seen;
	logic [25:0]            pat;
	logic [31:0]            cfg [7];
	int                     bad_count;
	int                     n_tests;

	tiss_top u_dut (.mclk(mclk), .srst(srst), .ce(ce), .bus_req(bus_req),
		.rd_data(rd_data), .pins(pins), .onchip(onchip),
		.timer_channel_input(tin));
	tiss_edge_model u_model (.mclk(mclk), .srst(srst), .tin(tin),
		.rise_seen(rise_seen));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic cmp(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, 0 after
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1 cmp("rd_data", {8'h00, e}, {8'h00, rd_data});
		@(posedge mclk);
		#1 cmp("rd_idle", 16'h0000, {8'h00, rd_data});
	endtask

	function automatic logic [15:0] ref_out(input logic [31:0] c);
		logic [15:0] e;
		logic [5:0]  can;
		can = onchip.can_timestamp_out;
		e = pins.port_pin;
		case (c[1+8:8])
			2'b01: e[0] = can[0];
			2'b11: e[0] = c[24] ? onchip.interval_timer_ch3_irq
				: pins.serial10_receive_line;
			default: ;
		endcase
		case (c[3+8:2+8])
			2'b01: e[1] = can[1];
			2'b11: e[1] = pins.serial11_receive_line;
			default: ;
		endcase
		if (c[6+8])
			e[2] = pins.serial2_receive_line;
		for (int g = 0; g < 5; g++)
			if (c[g])
				e[10+g] = can[g];
		if (c[5])
			e[15] = can[5];
		else if (c[25])
			e[15] = onchip.interval_timer_ch3_irq;
		for (int g = 0; g < 8; g++)
			if (c[16+g])
				e[2*g+1] = e[2*g];
		return e;
	endfunction

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		// fields: irq select, chain, receive, time stamp
		cfg = '{32'h0000_0000, 32'h0000_c115, 32'h0100_0fea,
			32'h0200_0700, 32'hffff_083f, 32'h0055_0300, 32'h01aa_0d20};
		bad_count = 0;
		n_tests = 0;
		srst = 1'b1;
		ce = 1'b1;
		bus_req = '0;
		{pins, onchip} = 26'h000_0000;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		rd(`TISS_ADDR_RX, 8'h00);
		rd(`TISS_ADDR_TS, 8'h00);
		rd(`TISS_ADDR_IT, 8'h00);
		rd(`TISS_ADDR_CHAIN, 8'h00);
		rd(32'hff77_1008, 8'h00);
		for (int c = 0; c < 7; c++) begin
			wr(`TISS_ADDR_IT, cfg[c][31:24]);
			wr(`TISS_ADDR_CHAIN, cfg[c][23:16]);
			wr(`TISS_ADDR_RX, cfg[c][15:8]);
			wr(`TISS_ADDR_TS, cfg[c][7:0]);
			rd(`TISS_ADDR_IT, cfg[c][31:24] & `TISS_MASK_IT);
			rd(`TISS_ADDR_CHAIN, cfg[c][23:16]);
			rd(`TISS_ADDR_RX, cfg[c][15:8] & `TISS_MASK_RX);
			rd(`TISS_ADDR_TS, cfg[c][7:0] & `TISS_MASK_TS);
			// bit k of index+1: sources differ and none stays low
			for (int k = 0; k < 5; k++) begin
				for (int i = 0; i < 26; i++)
					pat[i] = ((i + 1) >> k) % 2 != 0;
				@(posedge mclk);
				{pins, onchip} <= pat;
				repeat (4) @(posedge mclk);
				#1 cmp("tin", ref_out(cfg[c]), tin);
			end
		end
		cmp("rise_seen", 16'hffff, rise_seen);
		@(posedge mclk);
		ce <= 1'b0;
		wr(`TISS_ADDR_TS, 8'h00);
		ce <= 1'b1;
		rd(`TISS_ADDR_TS, 8'h20);
		complete_run();
	end

	initial begin
		#300us;
		bad_count++;
		complete_run();
	end
endmodule
